// ### rtl/vector_source_map.sv
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module vector_source_map #(
	parameter logic [24:0] SRC_PRESENT = vism_pkg::SRC_ALL
) (
	input  wire logic                            MCLK,
	input  wire logic                            RST,
	input  wire logic [7:0]                      ADDR,
	input  wire logic [31:0]                     WDATA,
	input  wire logic                            WR,
	input  wire logic                            RD,
	output logic      [31:0]                     RDATA,
	input  wire logic [vism_pkg::SRC_COUNT-1:0]  SRC_REQ,
	output logic      [vism_pkg::VEC_COUNT-1:0]  VEC_PEND,
	output logic      [vism_pkg::VEC_COUNT*2-1:0] VEC_SUBPRIO,
	output logic                                 IRQ_OUT
);
	import vism_pkg::*;

	logic [SRC_COUNT-1:0]  flags_w;
	logic [SRC_COUNT-1:0]  clr_w;
	logic [SRC_COUNT-1:0]  enables_q;
	logic [FIELD_W-1:0]    lane_q [VEC_COUNT];
	logic [VEC_COUNT-1:0]  hit_w;
	logic [VEC_COUNT-1:0]  vec_pend_d;
	logic [VEC_COUNT-1:0]  vec_pend_q;
	logic [VEC_COUNT*2-1:0] subprio_q;
	logic [31:0]           rdata_d;
	logic [31:0]           rdata_q;
	logic                  irq_q;
	logic                  wr_flags_w;
	logic                  wr_enables_w;

	// Returns the priority register index selected by an address, or 3 for none.
	function automatic int prio_reg_of(input logic [7:0] a);
		int r;
		r = PRIO_REG_COUNT;
		if (a == OFS_PRIO_NINE) begin
			r = 0;
		end else if (a == OFS_PRIO_TEN) begin
			r = 1;
		end else if (a == OFS_PRIO_ELEVEN) begin
			r = 2;
		end
		return r;
	endfunction

	// Packs the four lanes of one priority register into a word.
	function automatic logic [31:0] prio_word(input int r,
		input logic [FIELD_W-1:0] l0, input logic [FIELD_W-1:0] l1,
		input logic [FIELD_W-1:0] l2, input logic [FIELD_W-1:0] l3);
		logic [31:0] w;
		w = {3'h0, l3, 3'h0, l2, 3'h0, l1, 3'h0, l0};
		if (r >= PRIO_REG_COUNT) begin
			w = 32'h00000000;
		end
		return w;
	endfunction

	assign wr_flags_w   = WR && (ADDR == OFS_FLAGS);
	assign wr_enables_w = WR && (ADDR == OFS_ENABLES);

	// Writing a one to a flag bit clears it.
	assign clr_w = wr_flags_w ? WDATA[31:FLAG_LSB] : FLAGS_RST;

	// One flag cell per request source; DMA sources are edge-only.
	for (genvar i = 0; i < SRC_COUNT; i++) begin : g_src
		irq_flag_cell #(
			.PERSISTENT (i < NONPERSIST_SRC),
			.PRESENT    (SRC_PRESENT[i])
		) u_cell (
			.MCLK (MCLK),
			.RST  (RST),
			.REQ  (SRC_REQ[i]),
			.CLR  (clr_w[i]),
			.FLAG (flags_w[i])
		);
	end

	// Enable register; bits of absent sources stay zero.
	always_ff @(posedge MCLK) begin
		if (RST) begin
			enables_q <= ENABLES_RST;
		end else if (wr_enables_w) begin
			enables_q <= WDATA[31:FLAG_LSB] & SRC_PRESENT;
		end
	end

	// Priority lanes: only the five low bits of each byte are stored.
	always_ff @(posedge MCLK) begin
		if (RST) begin
			for (int v = 0; v < VEC_COUNT; v++) begin
				lane_q[v] <= LANE_RST;
			end
		end else if (WR && (prio_reg_of(ADDR) < PRIO_REG_COUNT)) begin
			for (int l = 0; l < LANES_PER_REG; l++) begin
				lane_q[prio_reg_of(ADDR) * LANES_PER_REG + l] <=
					WDATA[l*LANE_W +: FIELD_W];
			end
		end
	end

	// Read mux; unmapped offsets read as zero.
	always_comb begin
		int r;
		r = prio_reg_of(ADDR);
		rdata_d = RDATA_RST;
		if (ADDR == OFS_FLAGS) begin
			rdata_d = {flags_w, 7'h00};
		end else if (ADDR == OFS_ENABLES) begin
			rdata_d = {enables_q, 7'h00};
		end else if (r < PRIO_REG_COUNT) begin
			rdata_d = prio_word(r, lane_q[r*4], lane_q[r*4+1],
				lane_q[r*4+2], lane_q[r*4+3]);
		end
	end

	// Read data stands in the cycle after the read strobe only.
	always_ff @(posedge MCLK) begin
		if (RST) begin
			rdata_q <= RDATA_RST;
		end else begin
			rdata_q <= RD ? rdata_d : RDATA_RST;
		end
	end

	// Gathers enabled, flagged sources onto their vectors.
	always_comb begin
		hit_w = '0;
		for (int i = 0; i < SRC_COUNT; i++) begin
			if (flags_w[i] && enables_q[i]) begin
				hit_w[vec_of(i)] = 1'b1;
			end
		end
	end

	// A vector with priority zero is disabled.
	always_comb begin
		for (int v = 0; v < VEC_COUNT; v++) begin
			vec_pend_d[v] = hit_w[v] && (lane_q[v][PRIO_MSB:PRIO_LSB] != PRIO_OFF);
		end
	end

	// Registered vector requests and their subpriorities toward the core.
	always_ff @(posedge MCLK) begin
		if (RST) begin
			vec_pend_q <= '0;
			subprio_q  <= '0;
		end else begin
			vec_pend_q <= vec_pend_d;
			for (int v = 0; v < VEC_COUNT; v++) begin
				subprio_q[v*2 +: 2] <= lane_q[v][SUB_MSB:SUB_LSB];
			end
		end
	end

	// Level interrupt while any enabled flag is set.
	always_ff @(posedge MCLK) begin
		if (RST) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(flags_w & enables_q);
		end
	end

	assign RDATA       = rdata_q;
	assign VEC_PEND    = vec_pend_q;
	assign VEC_SUBPRIO = subprio_q;
	assign IRQ_OUT     = irq_q;

	// Assertions.
	sequence s_src_hit(int b, int v);
		flags_w[b] && enables_q[b] && (lane_q[v][PRIO_MSB:PRIO_LSB] != PRIO_OFF);
	endsequence

	serial_a_vec_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(2, 0) |=> VEC_PEND[0])
		else $error("Serial A transmit request missed vector 32.");

	i2c_a_vec_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(4, 1) |=> VEC_PEND[1])
		else $error("I2C A target request missed vector 33.");

	port_change_vec_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(8, 2) |=> VEC_PEND[2])
		else $error("Port C change request missed vector 34.");

	parallel_vec_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(10, 3) |=> VEC_PEND[3])
		else $error("Parallel port error request missed vector 35.");

	spi_b_vec_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(11, 4) |=> VEC_PEND[4])
		else $error("SPI B fault request missed vector 36.");

	serial_b_vec_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(16, 5) |=> VEC_PEND[5])
		else $error("Serial B transmit request missed vector 37.");

	i2c_b_vec_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(17, 6) |=> VEC_PEND[6])
		else $error("I2C B collision request missed vector 38.");

	dma_own_vec_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(24, 11) |=> VEC_PEND[11])
		else $error("DMA channel 3 request missed vector 43.");

	dma_alone_a: assert property (@(posedge MCLK) disable iff (RST)
		!(flags_w[23] && enables_q[23]) |=> !VEC_PEND[10])
		else $error("Vector 42 pending without DMA channel 2.");

	flag_bit_a: assert property (@(posedge MCLK) disable iff (RST)
		RD && (ADDR == OFS_FLAGS) |=> RDATA == {$past(flags_w), 7'h00})
		else $error("Flag register read does not show flags at n-32.");

	lane_write_a: assert property (@(posedge MCLK) disable iff (RST)
		WR && (ADDR == OFS_PRIO_TEN) |=> lane_q[7] == $past(WDATA[28:24]))
		else $error("Lane 3 of the tenth register not stored for vector 39.");

	lane_zero_a: assert property (@(posedge MCLK) disable iff (RST)
		RD |=> (RDATA[31:29] == 3'h0) || ($past(ADDR) == OFS_FLAGS)
			|| ($past(ADDR) == OFS_ENABLES))
		else $error("Reserved lane bits read nonzero.");

	absent_enable_a: assert property (@(posedge MCLK) disable iff (RST)
		(enables_q & ~SRC_PRESENT) == '0)
		else $error("Absent source has an enable set.");

	prio_off_a: assert property (@(posedge MCLK) disable iff (RST)
		lane_q[0][PRIO_MSB:PRIO_LSB] == PRIO_OFF |=> !VEC_PEND[0])
		else $error("Disabled vector 32 presented pending.");

	no_hit_a: assert property (@(posedge MCLK) disable iff (RST)
		!hit_w[3] |=> !VEC_PEND[3])
		else $error("Vector 35 pending without an enabled flag.");

	// Every other source must reach its own vector one cycle after it is live.
	src00_route_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(0, 0) |=> VEC_PEND[0])
		else $error("Request 39 missed vector 32.");

	src01_route_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(1, 0) |=> VEC_PEND[0])
		else $error("Request 40 missed vector 32.");

	src03_route_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(3, 1) |=> VEC_PEND[1])
		else $error("Request 42 missed vector 33.");

	src05_route_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(5, 1) |=> VEC_PEND[1])
		else $error("Request 44 missed vector 33.");

	src06_route_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(6, 2) |=> VEC_PEND[2])
		else $error("Request 45 missed vector 34.");

	src07_route_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(7, 2) |=> VEC_PEND[2])
		else $error("Request 46 missed vector 34.");

	src09_route_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(9, 3) |=> VEC_PEND[3])
		else $error("Request 48 missed vector 35.");

	src12_route_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(12, 4) |=> VEC_PEND[4])
		else $error("Request 51 missed vector 36.");

	src13_route_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(13, 4) |=> VEC_PEND[4])
		else $error("Request 52 missed vector 36.");

	src14_route_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(14, 5) |=> VEC_PEND[5])
		else $error("Request 53 missed vector 37.");

	src15_route_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(15, 5) |=> VEC_PEND[5])
		else $error("Request 54 missed vector 37.");

	src18_route_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(18, 6) |=> VEC_PEND[6])
		else $error("Request 57 missed vector 38.");

	src19_route_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(19, 6) |=> VEC_PEND[6])
		else $error("Request 58 missed vector 38.");

	src20_route_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(20, 7) |=> VEC_PEND[7])
		else $error("Request 59 missed vector 39.");

	src21_route_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(21, 8) |=> VEC_PEND[8])
		else $error("Request 60 missed vector 40.");

	src22_route_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(22, 9) |=> VEC_PEND[9])
		else $error("Request 61 missed vector 41.");

	src23_route_a: assert property (@(posedge MCLK) disable iff (RST)
		s_src_hit(23, 10) |=> VEC_PEND[10])
		else $error("Request 62 missed vector 42.");

	enable_write_a: assert property (@(posedge MCLK) disable iff (RST)
		wr_enables_w |=> enables_q == ($past(WDATA[31:FLAG_LSB]) & SRC_PRESENT))
		else $error("Enable register write not stored at n-32.");

	subprio_out_a: assert property (@(posedge MCLK) disable iff (RST)
		lane_q[4][SUB_MSB:SUB_LSB] == 2'h3 |=> VEC_SUBPRIO[9:8] == 2'h3)
		else $error("Subpriority of vector 36 not presented.");

	rdata_idle_a: assert property (@(posedge MCLK) disable iff (RST)
		!RD |=> RDATA == RDATA_RST)
		else $error("Read data stands without a read strobe.");

	irq_level_a: assert property (@(posedge MCLK) disable iff (RST)
		|(flags_w & enables_q) |=> IRQ_OUT)
		else $error("Interrupt output low with an enabled flag set.");

	irq_quiet_a: assert property (@(posedge MCLK) disable iff (RST)
		(flags_w & enables_q) == '0 |=> !IRQ_OUT)
		else $error("Interrupt output high with no enabled flag set.");

endmodule

// ### rtl/vism_pkg.sv
package vism_pkg;

	// Register byte offsets on the plain register port.
	localparam logic [7:0] OFS_FLAGS       = 8'h00;
	localparam logic [7:0] OFS_ENABLES     = 8'h04;
	localparam logic [7:0] OFS_PRIO_NINE   = 8'h08;
	localparam logic [7:0] OFS_PRIO_TEN    = 8'h0c;
	localparam logic [7:0] OFS_PRIO_ELEVEN = 8'h10;

	// Source and vector geometry.
	localparam int SRC_COUNT       = 25;
	localparam int VEC_COUNT       = 12;
	localparam int PRIO_REG_COUNT  = 3;
	localparam int LANES_PER_REG   = 4;
	localparam int FIRST_IRQ       = 39;
	localparam int FIRST_VECTOR    = 32;
	localparam int FLAG_LSB        = FIRST_IRQ - 32;
	localparam int NONPERSIST_SRC  = 60 - FIRST_IRQ;

	// Field layout of one priority byte lane.
	localparam int LANE_W     = 8;
	localparam int FIELD_W    = 5;
	localparam int PRIO_LSB   = 2;
	localparam int PRIO_MSB   = 4;
	localparam int SUB_LSB    = 0;
	localparam int SUB_MSB    = 1;

	// Reset values.
	localparam logic [SRC_COUNT-1:0] SRC_ALL     = 25'h1ffffff;
	localparam logic [SRC_COUNT-1:0] FLAGS_RST   = 25'h0000000;
	localparam logic [SRC_COUNT-1:0] ENABLES_RST = 25'h0000000;
	localparam logic [FIELD_W-1:0]   LANE_RST    = 5'h00;
	localparam logic [2:0]           PRIO_OFF    = 3'h0;
	localparam logic [31:0]          RDATA_RST   = 32'h00000000;

	// Maps a source index (request number minus 39) to a vector index (vector minus 32).
	function automatic logic [3:0] vec_of(input int src);
		logic [3:0] v;
		v = 4'h0;
		if (src < 3) begin
			v = 4'h0;
		end else if (src < 6) begin
			v = 4'h1;
		end else if (src < 9) begin
			v = 4'h2;
		end else if (src < 11) begin
			v = 4'h3;
		end else if (src < 14) begin
			v = 4'h4;
		end else if (src < 17) begin
			v = 4'h5;
		end else if (src < 20) begin
			v = 4'h6;
		end else if (src < 21) begin
			v = 4'h7;
		end else begin
			v = 4'(src - 13);
		end
		return v;
	endfunction

endpackage

// ### rtl/irq_flag_cell.sv
`timescale 1ns/1ns
module irq_flag_cell #(
	parameter bit PERSISTENT = 1'b1,
	parameter bit PRESENT    = 1'b1
) (
	input  wire logic MCLK,
	input  wire logic RST,
	input  wire logic REQ,
	input  wire logic CLR,
	output logic      FLAG
);
	import vism_pkg::*;

	logic req_prev_q;
	logic flag_q;
	logic set_w;

	// A persistent source sets the flag every cycle its request is high; a
	// non-persistent one only on the rising edge of its request.
	assign set_w = PRESENT && (PERSISTENT ? REQ : (REQ && !req_prev_q));

	// Request history for edge detection.
	always_ff @(posedge MCLK) begin
		if (RST) begin
			req_prev_q <= 1'b0;
		end else begin
			req_prev_q <= REQ;
		end
	end

	// Sticky flag; a set in the same cycle as a clear wins.
	always_ff @(posedge MCLK) begin
		if (RST) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= set_w || (flag_q && !CLR);
		end
	end

	assign FLAG = flag_q;

	persist_set_a: assert property (@(posedge MCLK) disable iff (RST)
		PERSISTENT && PRESENT && REQ |=> flag_q)
		else $error("Persistent request did not hold its flag.");

	dma_edge_a: assert property (@(posedge MCLK) disable iff (RST)
		!PERSISTENT && req_prev_q && REQ && CLR |=> !flag_q)
		else $error("Held non-persistent request set its flag again.");

	absent_idle_a: assert property (@(posedge MCLK) disable iff (RST)
		!PRESENT |-> !flag_q)
		else $error("Absent source shows a flag.");

endmodule

// ### verification/src_model.sv
`timescale 1ns/1ns
// Peripheral event sources: each request line leaves its peripheral from a flop.
module src_model (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [24:0] lvl,
	output logic      [24:0] src_req
);
	// A source holds its request while its condition holds, one clock after the bench asks.
	always_ff @(posedge mclk) begin
		if (rst) begin
			src_req <= 25'h0000000;
		end else begin
			src_req <= lvl;
		end
	end
endmodule

// ### verification/tb_vector_source_map.sv
`timescale 1ns/1ns
module tb_vector_source_map;
	import vism_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [24:0] lvl = 25'h0000000;
	logic [24:0] src_req;
	logic [31:0] rdata;
	logic [11:0] vec_pend;
	logic [11:0] pend_s;
	logic [23:0] vec_sub;
	logic        irq_out;
	logic [31:0] seed = 32'h00008c58;
	logic [31:0] r;
	logic [31:0] en;
	logic [31:0] pw [3];
	logic [11:0] exp_p;
	logic [23:0] exp_s;
	int          v;
	int          error_cnt = 0;
	int          num_checks = 0;

	// The clock toggles every half period of 10 ns.
	always #10 mclk = ~mclk;

	src_model u_src (.mclk(mclk), .rst(rst), .lvl(lvl), .src_req(src_req));

	vector_source_map u_dut (.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .SRC_REQ(src_req), .VEC_PEND(vec_pend),
		.VEC_SUBPRIO(vec_sub), .IRQ_OUT(irq_out));

	// A smaller variant that lacks the first serial port fault source.
	vector_source_map #(.SRC_PRESENT(25'h1fffffe)) u_small (.MCLK(mclk), .RST(rst),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(), .SRC_REQ(src_req),
		.VEC_PEND(pend_s), .VEC_SUBPRIO(), .IRQ_OUT());

	// Counts a comparison and reports it if the values differ.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Vector index of a request number, from the first request of each vector.
	function automatic int exp_vec(input int n);
		int starts [12] = '{39, 42, 45, 48, 50, 53, 56, 59, 60, 61, 62, 63};
		int k;
		k = 0;
		for (int j = 0; j < 12; j++) begin
			if (n >= starts[j]) begin
				k = j;
			end
		end
		return k;
	endfunction

	task automatic test_done();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// The watchdog cuts a hung run short.
	initial begin
		#200000;
		error_cnt++;
		test_done();
	end

	// Main sequence: reset values, lane fields, source mapping, random gating.
	initial begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		for (int a = 0; a < 6; a++) begin
			rreg(8'(a * 4), r);
			chk(r, 32'h00000000);
		end
		wreg(8'h14, 32'hffffffff);
		rreg(8'h14, r);
		chk(r, 32'h00000000);
		for (int k = 0; k < 9; k++) begin
			seed = xs(seed);
			pw[k % 3] = seed & 32'h1f1f1f1f;
			wreg(OFS_PRIO_NINE + 8'(4 * (k % 3)), seed);
			rreg(OFS_PRIO_NINE + 8'(4 * (k % 3)), r);
			chk(r, pw[k % 3]);
			@(posedge mclk);
			#1;
			chk(rdata, 32'h00000000);
		end
		exp_s = 24'h000000;
		for (int w = 0; w < 12; w++) begin
			exp_s[2 * w +: 2] = pw[w / 4][8 * (w % 4) +: 2];
		end
		chk(32'(vec_sub), 32'(exp_s));
		wreg(OFS_PRIO_NINE, 32'h07070707);
		wreg(OFS_PRIO_TEN, 32'h1f1e1d1c);
		wreg(OFS_PRIO_ELEVEN, 32'h04040404);
		wreg(OFS_ENABLES, 32'hffffffff);
		rreg(OFS_ENABLES, r);
		chk(r, 32'hffffff80);
		// Each source alone: its vector, its flag bit, and how a clear behaves while held.
		for (int i = 0; i < 25; i++) begin
			@(posedge mclk);
			lvl <= 25'(1) << i;
			repeat (3) @(posedge mclk);
			#1;
			chk(32'(vec_pend), 32'(1) << exp_vec(39 + i));
			chk(32'(irq_out), 32'h00000001);
			if (i == 0) begin
				chk(32'(pend_s), 32'h00000000);
			end
			rreg(OFS_FLAGS, r);
			chk(r, 32'(1) << (i + 7));
			wreg(OFS_FLAGS, 32'(1) << (i + 7));
			rreg(OFS_FLAGS, r);
			chk(r, (i < 21) ? 32'(1) << (i + 7) : 32'h00000000);
			@(posedge mclk);
			lvl <= 25'h0000000;
			wreg(OFS_FLAGS, 32'hffffff80);
		end
		// All sources held; random enables and priorities decide what is pending.
		@(posedge mclk);
		lvl <= 25'h1ffffff;
		for (int k = 0; k < 12; k++) begin
			seed = xs(seed);
			en = seed & 32'hffffff80;
			wreg(OFS_ENABLES, seed);
			for (int g = 0; g < 3; g++) begin
				seed = xs(seed);
				pw[g] = (k == 0) ? 32'h00000000 : seed & 32'h1f1f1f1f;
				wreg(OFS_PRIO_NINE + 8'(4 * g), pw[g]);
			end
			repeat (2) @(posedge mclk);
			#1;
			exp_p = 12'h000;
			for (int i = 0; i < 25; i++) begin
				v = exp_vec(39 + i);
				if (en[i + 7] && pw[v / 4][8 * (v % 4) + 2 +: 3] != 3'h0) begin
					exp_p[v] = 1'b1;
				end
			end
			chk(32'(vec_pend), 32'(exp_p));
			chk(32'(irq_out), 32'(en != 32'h00000000));
		end
		// Reset in mid-run: outputs and registers return to zero and stay quiet after it.
		@(posedge mclk);
		rst <= 1'b1;
		lvl <= 25'h0000000;
		repeat (3) @(posedge mclk);
		#1;
		chk(32'(vec_pend), 32'h00000000);
		chk(32'(vec_sub), 32'h00000000);
		chk(32'(irq_out), 32'h00000000);
		@(posedge mclk);
		rst <= 1'b0;
		rreg(OFS_ENABLES, r);
		chk(r, 32'h00000000);
		rreg(OFS_PRIO_TEN, r);
		chk(r, 32'h00000000);
		rreg(OFS_FLAGS, r);
		chk(r, 32'h00000000);
		test_done();
	end
endmodule
